// >>> rstctl_pkg.sv
// constants shared by the reset supervision block
package rstctl_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BROWNOUT_MIN_PULSE_NS = 2000;
  localparam int BROWNOUT_MIN_CYCLES =
    (BROWNOUT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_STARTUP_NS = 40000;
  localparam int STARTUP_DELAY_CYCLES = 16;
  // brown-out level fuse code that switches the detector off
  localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;
  // register map
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_CAUSE = 12'h000;
  localparam logic [11:0] ADDR_WDOG = 12'h004;
  // reset cause field positions and reset value
  localparam int WATCHDOG_RESET_FLAG_POS = 3;
  localparam int BROWNOUT_RESET_FLAG_POS = 2;
  localparam int EXTERNAL_RESET_FLAG_POS = 1;
  localparam int POWERON_RESET_FLAG_POS = 0;
  localparam logic [3:0] CAUSE_RESET = 4'h1;
  // watchdog control field positions
  localparam int IRQ_FLAG_POS = 7;
  localparam int IRQ_EN_POS = 6;
  localparam int PRESCALE_HI_POS = 5;
  localparam int CHANGE_EN_POS = 4;
  localparam int RESET_EN_POS = 3;
  localparam int PRESCALE_LO_POS = 0;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  // watchdog period
  localparam int WDOG_CNT_W = 20;
  localparam logic [19:0] WDOG_BASE_CYCLES = 20'h00800;
  localparam logic [3:0] PRESCALE_MAX = 4'h9;
  localparam logic [2:0] CHANGE_WINDOW = 3'h4;
endpackage : rstctl_pkg

// >>> brownout_filter.sv
// glitch filter for the brown-out comparator output
`timescale 1ns/100ps
module brownout_filter #(
  parameter int MIN_CYCLES = rstctl_pkg::BROWNOUT_MIN_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic low_i,
  output logic reset_o
);
  localparam int W = $clog2(MIN_CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(MIN_CYCLES - 1);
  logic [W-1:0] cnt;

  if (MIN_CYCLES < 1)
  begin : g_chk
    $error("brownout_filter: MIN_CYCLES must be at least 1");
  end

  // count consecutive low cycles, reset only after a sustained dip
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !enable_i || !low_i)
    begin
      cnt <= '0;
      reset_o <= 1'b0;
    end
    else
    begin
      if (cnt != LAST)
      begin
        cnt <= cnt + W'(1);
      end
      reset_o <= (cnt == LAST);
    end
  end
endmodule : brownout_filter

// >>> startup_delay.sv
// start-up delay counter that stretches the internal reset
`timescale 1ns/100ps
module startup_delay #(
  parameter int DELAY_CYCLES = rstctl_pkg::STARTUP_DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hold_i,
  output logic reset_o
);
  localparam int W = $clog2(DELAY_CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(DELAY_CYCLES);
  logic [W-1:0] cnt;

  if (DELAY_CYCLES < 1)
  begin : g_chk
    $error("startup_delay: DELAY_CYCLES must be at least 1");
  end

  // reload while any source holds, count down once all have gone
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= LOAD;
      reset_o <= 1'b1;
    end
    else if (hold_i)
    begin
      cnt <= LOAD;
      reset_o <= 1'b1;
    end
    else
    begin
      if (cnt != '0)
      begin
        cnt <= cnt - W'(1);
      end
      reset_o <= (cnt > W'(1));
    end
  end
endmodule : startup_delay

// >>> watchdog_reset_control.sv
// reset supervision: brown-out, watchdog, reset cause and reference enable
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
module watchdog_reset_control #(
  parameter int BROWNOUT_MIN_CYCLES = rstctl_pkg::BROWNOUT_MIN_CYCLES,
  parameter int STARTUP_DELAY_CYCLES = rstctl_pkg::STARTUP_DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rstctl_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // reset sources and fuses
  input wire logic poweron_i,
  input wire logic external_reset_i,
  input wire logic supply_low_i,
  input wire logic [2:0] brownout_level_fuses_i,
  input wire logic watchdog_always_on_fuse_i,
  // watchdog oscillator and cpu side
  input wire logic wdog_osc_i,
  input wire logic wdog_restart_i,
  input wire logic wdog_irq_ack_i,
  // reference consumers
  input wire logic comparator_bandgap_select_i,
  input wire logic adc_enable_i,
  input wire logic dac_enable_i,
  // outputs
  output logic cpu_reset_o,
  output logic wdog_reset_pulse_o,
  output logic wdog_irq_o,
  output logic brownout_enable_o,
  output logic ref_power_o
);
  localparam int CW = rstctl_pkg::WDOG_CNT_W;

  logic brownout_detector_en;
  logic brownout_reset;
  logic any_source;
  logic [3:0] reset_cause_register;
  logic [3:0] next_cause;
  logic watchdog_reset_enable;
  logic watchdog_irq_enable;
  logic watchdog_irq_flag;
  logic [3:0] watchdog_prescale_select;
  logic [2:0] change_cnt;
  logic change_open;
  logic reset_en_eff;
  logic irq_en_eff;
  logic running;
  logic osc_q;
  logic osc_tick;
  logic [CW-1:0] wdog_cnt;
  logic [CW-1:0] wdog_limit;
  logic timeout;
  logic irq_timeout;
  logic reset_timeout;
  logic apb_access;
  logic apb_done;
  logic hit_cause;
  logic hit_wdog;
  logic wr_cause;
  logic wr_wdog;
  logic unlock_wr;
  logic window_wr;
  logic [31:0] rd_mux;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // brown-out enable decode
  assign brownout_detector_en =
    (brownout_level_fuses_i != rstctl_pkg::BROWNOUT_OFF_CODE);

  brownout_filter #(
    .MIN_CYCLES(BROWNOUT_MIN_CYCLES)
  ) u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(brownout_detector_en),
    .low_i(supply_low_i),
    .reset_o(brownout_reset)
  );

  // any active source holds the cpu, one clock delay on entry
  assign any_source = poweron_i | external_reset_i | brownout_reset
    | wdog_reset_pulse_o;

  startup_delay #(
    .DELAY_CYCLES(STARTUP_DELAY_CYCLES)
  ) u_delay (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .hold_i(any_source),
    .reset_o(cpu_reset_o)
  );

  // apb decode, one wait state in every access
  assign apb_access = psel_i & penable_i;
  assign apb_done = apb_access & pready_o;
  assign hit_cause = (paddr_i == rstctl_pkg::ADDR_CAUSE);
  assign hit_wdog = (paddr_i == rstctl_pkg::ADDR_WDOG);
  assign wr_cause = apb_done & pwrite_i & hit_cause;
  assign wr_wdog = apb_done & pwrite_i & hit_wdog & ~cpu_reset_o;
  assign unlock_wr = wr_wdog & pwdata_i[rstctl_pkg::CHANGE_EN_POS]
    & pwdata_i[rstctl_pkg::RESET_EN_POS];
  assign window_wr = wr_wdog & change_open
    & ~pwdata_i[rstctl_pkg::CHANGE_EN_POS];

  // apb handshake and registered read data
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= apb_access & ~pready_o;
      if (apb_access & ~pready_o)
      begin
        pslverr_o <= ~(hit_cause | hit_wdog);
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // read mux, unmapped and reserved bits read zero
  always_comb
  begin
    if (hit_cause)
    begin
      rd_mux = {28'h000_0000, reset_cause_register};
    end
    else if (hit_wdog)
    begin
      rd_mux = 32'h0000_0000;
      rd_mux[rstctl_pkg::IRQ_FLAG_POS] = watchdog_irq_flag;
      rd_mux[rstctl_pkg::IRQ_EN_POS] = irq_en_eff;
      rd_mux[rstctl_pkg::PRESCALE_HI_POS] = watchdog_prescale_select[3];
      rd_mux[rstctl_pkg::CHANGE_EN_POS] = change_open;
      rd_mux[rstctl_pkg::RESET_EN_POS] = reset_en_eff;
      rd_mux[rstctl_pkg::PRESCALE_LO_POS +: 3] = watchdog_prescale_select[2:0];
    end
    else
    begin
      rd_mux = 32'h0000_0000;
    end
  end

  // next reset cause: software clears, sources set and win
  always_comb
  begin
    next_cause = reset_cause_register;
    if (wr_cause)
    begin
      next_cause = reset_cause_register & pwdata_i[3:0];
    end
    if (poweron_i)
    begin
      next_cause = 4'h0;
      next_cause[rstctl_pkg::POWERON_RESET_FLAG_POS] = 1'b1;
    end
    else
    begin
      if (wdog_reset_pulse_o)
      begin
        next_cause[rstctl_pkg::WATCHDOG_RESET_FLAG_POS] = 1'b1;
      end
      if (brownout_reset)
      begin
        next_cause[rstctl_pkg::BROWNOUT_RESET_FLAG_POS] = 1'b1;
      end
      if (external_reset_i)
      begin
        next_cause[rstctl_pkg::EXTERNAL_RESET_FLAG_POS] = 1'b1;
      end
    end
  end

  // reset cause register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reset_cause_register <= rstctl_pkg::CAUSE_RESET;
    end
    else
    begin
      reset_cause_register <= next_cause;
    end
  end

  // effective mode bits, fuse and reset flag override
  assign reset_en_eff = watchdog_reset_enable | watchdog_always_on_fuse_i
    | reset_cause_register[rstctl_pkg::WATCHDOG_RESET_FLAG_POS];
  assign irq_en_eff = watchdog_irq_enable & ~watchdog_always_on_fuse_i;
  assign running = reset_en_eff | irq_en_eff;

  // change window, closes four cycles after unlock
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cpu_reset_o)
    begin
      change_cnt <= 3'h0;
    end
    else if (unlock_wr)
    begin
      change_cnt <= rstctl_pkg::CHANGE_WINDOW;
    end
    else if (change_cnt != 3'h0)
    begin
      change_cnt <= change_cnt - 3'h1;
    end
  end
  assign change_open = (change_cnt != 3'h0);

  // watchdog control bits
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cpu_reset_o)
    begin
      watchdog_reset_enable <= 1'b0;
      watchdog_irq_enable <= 1'b0;
      watchdog_prescale_select <= rstctl_pkg::PRESCALE_RESET;
    end
    else
    begin
      if (wr_wdog)
      begin
        watchdog_irq_enable <= pwdata_i[rstctl_pkg::IRQ_EN_POS];
        if (pwdata_i[rstctl_pkg::RESET_EN_POS])
        begin
          watchdog_reset_enable <= 1'b1;
        end
        else if (window_wr)
        begin
          watchdog_reset_enable <= 1'b0;
        end
        if (window_wr)
        begin
          watchdog_prescale_select <= {pwdata_i[rstctl_pkg::PRESCALE_HI_POS],
            pwdata_i[rstctl_pkg::PRESCALE_LO_POS +: 3]};
        end
      end
      if (wdog_irq_ack_i && watchdog_irq_flag && reset_en_eff)
      begin
        watchdog_irq_enable <= 1'b0;
      end
    end
  end

  // interrupt flag: timeout sets and wins, write one or ack clears
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cpu_reset_o)
    begin
      watchdog_irq_flag <= 1'b0;
    end
    else if (irq_timeout)
    begin
      watchdog_irq_flag <= 1'b1;
    end
    else if (wdog_irq_ack_i || (wr_wdog && pwdata_i[rstctl_pkg::IRQ_FLAG_POS]))
    begin
      watchdog_irq_flag <= 1'b0;
    end
  end

  // period: 2048 oscillator cycles doubled per code step up to code 9, higher codes as 9
  always_comb
  begin
    if (watchdog_prescale_select > rstctl_pkg::PRESCALE_MAX)
    begin
      wdog_limit = (rstctl_pkg::WDOG_BASE_CYCLES << rstctl_pkg::PRESCALE_MAX)
        - 20'h00001;
    end
    else
    begin
      wdog_limit = (rstctl_pkg::WDOG_BASE_CYCLES << watchdog_prescale_select)
        - 20'h00001;
    end
  end

  // oscillator edge detect
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_q <= 1'b0;
    end
    else
    begin
      osc_q <= wdog_osc_i;
    end
  end
  assign osc_tick = wdog_osc_i & ~osc_q;

  // watchdog counter on oscillator edges
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cpu_reset_o || !running || wdog_restart_i)
    begin
      wdog_cnt <= '0;
    end
    else if (osc_tick)
    begin
      if (wdog_cnt == wdog_limit)
      begin
        wdog_cnt <= '0;
      end
      else
      begin
        wdog_cnt <= wdog_cnt + 20'h00001;
      end
    end
  end

  // time-out action by mode
  assign timeout = osc_tick & running & ~wdog_restart_i & ~cpu_reset_o
    & (wdog_cnt == wdog_limit);
  assign irq_timeout = timeout & irq_en_eff
    & ~(reset_en_eff & watchdog_irq_flag);
  assign reset_timeout = timeout & reset_en_eff & ~irq_timeout;

  // one clock reset pulse
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wdog_reset_pulse_o <= 1'b0;
    end
    else
    begin
      wdog_reset_pulse_o <= reset_timeout & ~wdog_reset_pulse_o;
    end
  end

  // registered status outputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wdog_irq_o <= 1'b0;
      brownout_enable_o <= 1'b0;
      ref_power_o <= 1'b0;
    end
    else
    begin
      wdog_irq_o <= watchdog_irq_flag & irq_en_eff;
      brownout_enable_o <= brownout_detector_en;
      ref_power_o <= brownout_detector_en | comparator_bandgap_select_i
        | adc_enable_i | dac_enable_i;
    end
  end

  // checks next to the logic
  a_brownout_decode: assert property (
    ##1 brownout_enable_o == ($past(brownout_level_fuses_i) != 3'h7))
    else $error("brown-out enable does not follow fuse decode");
  a_brownout_entry: assert property (
    brownout_reset |=> cpu_reset_o)
    else $error("brown-out did not hold cpu in reset");
  a_release_hold: assert property (
    $fell(any_source) |-> cpu_reset_o ##1 cpu_reset_o)
    else $error("cpu released before start-up delay");
  a_pulse_single: assert property (
    wdog_reset_pulse_o |=> !wdog_reset_pulse_o)
    else $error("watchdog reset pulse longer than one clock");
  a_pulse_stretch: assert property (
    wdog_reset_pulse_o |=> cpu_reset_o [*2])
    else $error("watchdog reset not stretched");
  a_cause_reserved: assert property (
    (apb_access && !pready_o && hit_cause && !pwrite_i) |=> prdata_o[31:4] == 28'h0)
    else $error("reserved cause bits not zero");
  a_poweron_flags: assert property (
    poweron_i |=> reset_cause_register == 4'h1)
    else $error("power-on did not set only its flag");
  a_fuse_lock: assert property (
    watchdog_always_on_fuse_i [*2] |-> !wdog_irq_o)
    else $error("interrupt raised with always-on fuse");
  a_window_close: assert property (
    unlock_wr ##1 !unlock_wr [*4] |=> !change_open)
    else $error("change window not closed after four cycles");
  a_enable_locked: assert property (
    (wr_wdog && !change_open && watchdog_reset_enable) |=> watchdog_reset_enable)
    else $error("reset enable cleared outside window");
  a_irq_no_reset: assert property (
    (timeout && irq_en_eff && !reset_en_eff) |=> !wdog_reset_pulse_o)
    else $error("interrupt mode produced a reset");
endmodule : watchdog_reset_control

// >>> test_watchdog_reset_control.sv
// self-checking testbench for the reset supervision block
`timescale 1ns/100ps
module test_watchdog_reset_control;
  localparam int MINC = 4;
  localparam int DLY = 4;
  localparam logic [11:0] A_CA = rstctl_pkg::ADDR_CAUSE;
  localparam logic [11:0] A_WD = rstctl_pkg::ADDR_WDOG;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic poweron_i = 1'b0;
  logic external_reset_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic [2:0] brownout_level_fuses_i = 3'h7;
  logic watchdog_always_on_fuse_i = 1'b0;
  logic wdog_osc_i = 1'b0;
  logic wdog_restart_i = 1'b0;
  logic wdog_irq_ack_i = 1'b0;
  logic comparator_bandgap_select_i = 1'b0;
  logic adc_enable_i = 1'b0;
  logic dac_enable_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, cpu_reset_o, wdog_reset_pulse_o, wdog_irq_o;
  logic brownout_enable_o, ref_power_o;
  logic osc_run = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int n;

  watchdog_reset_control #(.BROWNOUT_MIN_CYCLES(MINC), .STARTUP_DELAY_CYCLES(DLY)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .poweron_i(poweron_i),
    .external_reset_i(external_reset_i), .supply_low_i(supply_low_i),
    .brownout_level_fuses_i(brownout_level_fuses_i),
    .watchdog_always_on_fuse_i(watchdog_always_on_fuse_i), .wdog_osc_i(wdog_osc_i),
    .wdog_restart_i(wdog_restart_i), .wdog_irq_ack_i(wdog_irq_ack_i),
    .comparator_bandgap_select_i(comparator_bandgap_select_i),
    .adc_enable_i(adc_enable_i), .dac_enable_i(dac_enable_i), .cpu_reset_o(cpu_reset_o),
    .wdog_reset_pulse_o(wdog_reset_pulse_o), .wdog_irq_o(wdog_irq_o),
    .brownout_enable_o(brownout_enable_o), .ref_power_o(ref_power_o)
  );

  // system clock and fast watchdog oscillator
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (osc_run) wdog_osc_i <= ~wdog_osc_i;

  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic sig(input int k);
    case (k)
      0: return cpu_reset_o;
      1: return wdog_reset_pulse_o;
      default: return wdog_irq_o;
    endcase
  endfunction : sig

  // bounded wait for an output level, cycles used returned
  task automatic wait_lvl(input string nm, input int k, input logic v, input int lim,
                          output int cnt);
    cnt = 0;
    while (sig(k) !== v && cnt < lim)
    begin
      @(posedge clk_i);
      cnt++;
    end
    if (sig(k) !== v)
    begin
      chk(nm, 32'(v), 32'(sig(k)));
      final_report();
    end
  endtask : wait_lvl

  // one apb transfer; more keeps psel up for a back-to-back setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic more, output logic [31:0] rd, output logic err);
    int c;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end while (pready_o !== 1'b1 && c < 50);
    rd = prdata_o;
    err = pslverr_o;
    penable_i <= 1'b0;
    if (!more)
    begin
      psel_i <= 1'b0;
      @(posedge clk_i);
    end
    if (c >= 50)
    begin
      chk("pready", 32'h1, 32'h0);
      final_report();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic more = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, more, r, e);
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 1'b0, r, e);
    chk(nm, exp, r);
    chk(nm, 32'(a != A_CA && a != A_WD), 32'(e));
  endtask : rdchk

  // reset values, unmapped address
  task t_regs;
    rdchk("cause_rst", A_CA, 32'(rstctl_pkg::CAUSE_RESET));
    rdchk("ctrl_rst", A_WD, 32'h0);
    wr(12'h008, 32'hFF);
    rdchk("unmapped", 12'h008, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // fuse decode, reference enable, glitch filter and release delay
  task t_brownout;
    logic bad;
    for (int f = 0; f < 8; f++)
    begin
      brownout_level_fuses_i <= 3'(f);
      repeat (3) @(posedge clk_i);
      chk("bod_en", 32'(f != 7), 32'(brownout_enable_o));
      chk("ref_bod", 32'(f != 7), 32'(ref_power_o));
    end
    for (int i = 0; i < 8; i++)
    begin
      {comparator_bandgap_select_i, adc_enable_i, dac_enable_i} <= 3'(i);
      repeat (3) @(posedge clk_i);
      chk("ref_consumers", 32'(i != 0), 32'(ref_power_o));
    end
    // detector off, consumers on: give the reference its start-up time
    repeat (rstctl_pkg::REF_STARTUP_NS / rstctl_pkg::CLK_PERIOD_NS) @(posedge clk_i);
    chk("ref_settled", 32'h1, 32'(ref_power_o));
    {comparator_bandgap_select_i, adc_enable_i, dac_enable_i} <= 3'h0;
    brownout_level_fuses_i <= 3'h0;
    supply_low_i <= 1'b1;
    repeat (MINC - 1) @(posedge clk_i);
    supply_low_i <= 1'b0;
    bad = 1'b0;
    repeat (12)
    begin
      @(posedge clk_i);
      bad = bad | cpu_reset_o;
    end
    chk("short_dip", 32'h0, 32'(bad));
    supply_low_i <= 1'b1;
    wait_lvl("bod_reset", 0, 1'b1, MINC + 4, n);
    repeat (5) @(posedge clk_i);
    supply_low_i <= 1'b0;
    repeat (DLY) @(posedge clk_i);
    chk("bod_hold", 32'h1, 32'(cpu_reset_o));
    wait_lvl("bod_release", 0, 1'b0, 6, n);
    rdchk("cause_bod", A_CA, 32'h5);
    wr(A_CA, 32'h0);
    rdchk("cause_clear", A_CA, 32'h0);
    $display("test brownout done");
  endtask : t_brownout

  // external and power-on sources against the cause flags
  task t_cause;
    for (int s = 0; s < 3; s++)
    begin
      if (s == 1)
        poweron_i <= 1'b1;
      else
        external_reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      poweron_i <= 1'b0;
      external_reset_i <= 1'b0;
      wait_lvl("src_release", 0, 1'b0, DLY + 6, n);
      rdchk("cause_src", A_CA, (s == 0) ? 32'h2 : (s == 1) ? 32'h1 : 32'h3);
    end
    wr(A_CA, 32'h0);
    $display("test cause done");
  endtask : t_cause

  // reset mode time-out: pulse, stretched reset, forced enable
  task t_wdog_reset;
    wr(A_WD, 32'h08);
    osc_run <= 1'b1;
    wait_lvl("wdog_pulse", 1, 1'b1, 6000, n);
    chk("period", 32'h1, 32'(n > 4080 && n < 4110));
    chk("no_irq_rst", 32'h0, 32'(wdog_irq_o));
    @(posedge clk_i);
    chk("pulse_width", 32'h0, 32'(wdog_reset_pulse_o));
    chk("reset_after", 32'h1, 32'(cpu_reset_o));
    osc_run <= 1'b0;
    wait_lvl("wdog_release", 0, 1'b0, DLY + 4, n);
    rdchk("cause_wdog", A_CA, 32'h8);
    rdchk("ctrl_forced", A_WD, 32'h08);
    wr(A_CA, 32'h0);
    rdchk("ctrl_free", A_WD, 32'h0);
    $display("test watchdog reset done");
  endtask : t_wdog_reset

  // interrupt mode with restarts, then combined mode
  task t_wdog_irq;
    wr(A_WD, 32'h40);
    osc_run <= 1'b1;
    repeat (3)
    begin
      repeat (3000) @(posedge clk_i);
      wdog_restart_i <= 1'b1;
      @(posedge clk_i);
      wdog_restart_i <= 1'b0;
    end
    chk("restart", 32'h0, 32'(wdog_irq_o));
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1)
        wr(A_WD, 32'h48);
      osc_run <= 1'b1;
      wait_lvl("irq", 2, 1'b1, 6000, n);
      chk("no_reset", 32'h0, 32'(cpu_reset_o | wdog_reset_pulse_o));
      osc_run <= 1'b0;
      wdog_irq_ack_i <= 1'b1;
      @(posedge clk_i);
      wdog_irq_ack_i <= 1'b0;
      rdchk("ctrl_ack", A_WD, (m == 0) ? 32'h40 : 32'h08);
    end
    $display("test watchdog irq done");
  endtask : t_wdog_irq

  // timed change sequence
  task t_timed;
    wr(A_WD, 32'h01);
    rdchk("locked", A_WD, 32'h08);
    wr(A_WD, 32'h18, 1'b1);
    rdchk("window_open", A_WD, 32'h18);
    rdchk("window_shut", A_WD, 32'h08);
    wr(A_WD, 32'h18, 1'b1);
    wr(A_WD, 32'h01);
    rdchk("changed", A_WD, 32'h01);
    wr(A_WD, 32'h18, 1'b1);
    wr(A_WD, 32'h00);
    $display("test timed done");
  endtask : t_timed

  // always-on fuse locks the mode
  task t_fuse;
    watchdog_always_on_fuse_i <= 1'b1;
    wr(A_WD, 32'h40);
    rdchk("fuse_lock", A_WD, 32'h08);
    watchdog_always_on_fuse_i <= 1'b0;
    wr(A_WD, 32'h00);
    rdchk("fuse_off", A_WD, 32'h0);
    $display("test fuse done");
  endtask : t_fuse

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_lvl("start", 0, 1'b0, 30, n);
    t_regs();
    t_brownout();
    t_cause();
    t_wdog_reset();
    t_wdog_irq();
    t_timed();
    t_fuse();
    final_report();
  end
endmodule : test_watchdog_reset_control
